// *** rtl/wei_consts.vh ***
// Constants for the wake event indicator block
`ifndef WEI_CONSTS_VH
`define WEI_CONSTS_VH

// Register word addresses on the plain register port
`define WEI_ADDR_W 8
`define WEI_ADDR_PWR_CTRL 8'h84
`define WEI_ADDR_IRQ_STAT 8'h90
`define WEI_ADDR_IRQ_EN 8'h94
`define WEI_ADDR_IRQ_CLR 8'h98

// Power control register field positions
`define WEI_BIT_READY 0
`define WEI_BIT_PIN_EN 1
`define WEI_BIT_POL 2
`define WEI_BIT_PULSE 3
`define WEI_BIT_CAUSE_LO 4
`define WEI_BIT_CAUSE_HI 5
`define WEI_BIT_DRIVE 6
`define WEI_BIT_ENERGY_EN 8
`define WEI_BIT_MAGIC_EN 9
`define WEI_BIT_PSTATE_LO 12
`define WEI_BIT_PSTATE_HI 13

// Wake cause codes
`define WEI_CAUSE_NONE 2'h0
`define WEI_CAUSE_ENERGY 2'h1
`define WEI_CAUSE_FRAME 2'h2
`define WEI_CAUSE_MULTI 2'h3

// Full-power state code of the power state field
`define WEI_PSTATE_FULL 2'h0

// Interrupt status bit positions
`define WEI_IRQ_ENERGY 0
`define WEI_IRQ_FRAME 1
`define WEI_IRQ_READY 2
`define WEI_IRQ_W 3

// Pulse length: 50 ms at 4 ns per cycle
`define WEI_PULSE_MS 50
`define WEI_CLK_PERIOD_NS 4
// Sized to the counter width: 50 ms / 4 ns = 12500000 cycles
`define WEI_PULSE_CYCLES 24'hBEBC20
`define WEI_PULSE_CNT_W 24

`endif

// *** rtl/wei_wake_event_indicator.v ***
// Wake cause recording, power event pin and readiness report
`timescale 1ns/1ps
`default_nettype none
`include "wei_consts.vh"

module wei_wake_event_indicator #(
    parameter [`WEI_PULSE_CNT_W-1:0] PULSE_CYCLES = `WEI_PULSE_CYCLES
) (
    input wire clk,
    input wire rst_b,
    input wire [`WEI_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire energy_event,
    input wire frame_event,
    input wire energy_src_pending,
    input wire frame_src_pending,
    input wire [1:0] power_state,
    input wire device_stable,
    output wire power_event_pin_o,
    output wire power_event_pin_oe,
    output wire power_event_irq,
    output wire irq
);

    // Control fields written by software, then cause, ready, status and pin state
    reg pin_en_q;
    reg pol_q;
    reg pulse_sel_q;
    reg drive_q;
    reg energy_en_q;
    reg magic_en_q;
    reg [1:0] cause_q;
    reg [1:0] cause_d;
    reg ready_q;
    reg [`WEI_IRQ_W-1:0] irq_stat_q;
    reg [`WEI_IRQ_W-1:0] irq_en_q;
    reg [`WEI_PULSE_CNT_W-1:0] pulse_cnt_q;
    reg pulse_q;
    reg pin_act_q;

    // Pin state machine, one-hot
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_PULSE = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;
    reg [2:0] state_q;

    wire wr_ctrl = reg_wr && (reg_addr == `WEI_ADDR_PWR_CTRL);
    wire energy_hit = energy_event && energy_en_q;
    wire frame_hit = frame_event && magic_en_q;
    wire any_hit = energy_hit || frame_hit;
    wire clear_ok = ready_q && (power_state == `WEI_PSTATE_FULL);
    // A cause bit clears only when neither source is pending; code 11 needs both
    wire [1:0] src_busy = {frame_src_pending, energy_src_pending};
    wire [1:0] clr_req = wr_ctrl && clear_ok ?
        reg_wdata[`WEI_BIT_CAUSE_HI:`WEI_BIT_CAUSE_LO] : 2'h0;

    // Merge a new cause with the recorded one
    function [1:0] wei_merge;
        input [1:0] old_c;
        input [1:0] new_c;
        begin
            if (new_c == `WEI_CAUSE_NONE) begin
                wei_merge = old_c;
            end else if (old_c == `WEI_CAUSE_NONE || old_c == new_c) begin
                wei_merge = new_c;
            end else begin
                wei_merge = `WEI_CAUSE_MULTI;
            end
        end
    endfunction

    // Cause next value; a new event wins over a clear in the same cycle
    always @* begin
        cause_d = cause_q;
        if (clr_req[0] && !(|src_busy)) begin
            cause_d[0] = 1'b0;
        end
        if (clr_req[1] && !(|src_busy)) begin
            cause_d[1] = 1'b0;
        end
        if (energy_hit && frame_hit) begin
            cause_d = `WEI_CAUSE_MULTI;
        end else if (energy_hit) begin
            cause_d = wei_merge(cause_d, `WEI_CAUSE_ENERGY);
        end else if (frame_hit) begin
            cause_d = wei_merge(cause_d, `WEI_CAUSE_FRAME);
        end
    end

    // Control register and cause field
    always @(posedge clk) begin
        if (!rst_b) begin
            pin_en_q <= 1'b0;
            pol_q <= 1'b0;
            pulse_sel_q <= 1'b0;
            drive_q <= 1'b0;
            energy_en_q <= 1'b0;
            magic_en_q <= 1'b0;
            cause_q <= `WEI_CAUSE_NONE;
        end else begin
            cause_q <= cause_d;
            if (wr_ctrl) begin
                pin_en_q <= reg_wdata[`WEI_BIT_PIN_EN];
                pol_q <= reg_wdata[`WEI_BIT_POL];
                pulse_sel_q <= reg_wdata[`WEI_BIT_PULSE];
                drive_q <= reg_wdata[`WEI_BIT_DRIVE];
                energy_en_q <= reg_wdata[`WEI_BIT_ENERGY_EN];
                magic_en_q <= reg_wdata[`WEI_BIT_MAGIC_EN];
            end
        end
    end

    // Ready follows the stabilised indication from the power logic
    always @(posedge clk) begin
        if (!rst_b) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= device_stable;
        end
    end

    // Pin activity: pulse for a fixed time or hold until released
    always @(posedge clk) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            pulse_cnt_q <= {`WEI_PULSE_CNT_W{1'b0}};
            pin_act_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (any_hit) begin
                        state_q <= ST_PULSE;
                        pin_act_q <= 1'b1;
                        pulse_cnt_q <= PULSE_CYCLES - 1'b1;
                    end
                end
                ST_PULSE: begin
                    // Release when cause or enables are cleared
                    if (cause_d == `WEI_CAUSE_NONE || !(energy_en_q || magic_en_q)) begin
                        state_q <= ST_IDLE;
                        pin_act_q <= 1'b0;
                    end else if (pulse_sel_q && pulse_cnt_q == 0) begin
                        state_q <= ST_DONE;
                        pin_act_q <= 1'b0;
                    end else if (pulse_sel_q) begin
                        pulse_cnt_q <= pulse_cnt_q - 1'b1;
                    end
                    // With pulse select clear the pin simply stays active
                end
                ST_DONE: begin
                    // One pulse per recorded cause; rearm once the cause is cleared
                    if (cause_d == `WEI_CAUSE_NONE) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    pin_act_q <= 1'b0;
                end
            endcase
        end
    end

    // Pin drive; open-drain pulls low only, so it is always active low
    wire pin_on = pin_act_q && pin_en_q;
    assign power_event_pin_o = drive_q ? (pol_q ? pin_on : !pin_on) : 1'b0;
    assign power_event_pin_oe = drive_q ? 1'b1 : pin_on;
    // Interrupt independent of pin enable
    assign power_event_irq = pin_act_q;

    // Sticky status; set wins over a same-cycle clear
    wire [`WEI_IRQ_W-1:0] irq_set = {device_stable && !ready_q, frame_hit, energy_hit};
    wire wr_clr = reg_wr && (reg_addr == `WEI_ADDR_IRQ_CLR);
    always @(posedge clk) begin
        if (!rst_b) begin
            irq_stat_q <= {`WEI_IRQ_W{1'b0}};
            irq_en_q <= {`WEI_IRQ_W{1'b0}};
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_clr ? reg_wdata[`WEI_IRQ_W-1:0] : 3'h0)) | irq_set;
            if (reg_wr && reg_addr == `WEI_ADDR_IRQ_EN) begin
                irq_en_q <= reg_wdata[`WEI_IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irq_stat_q & irq_en_q);

    // Read data one cycle after the strobe, zero otherwise
    always @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `WEI_ADDR_PWR_CTRL: begin
                    reg_rdata <= {18'h0, power_state, 2'h0, magic_en_q, energy_en_q, 1'b0,
                        drive_q, cause_q, pulse_sel_q, pol_q, pin_en_q, ready_q};
                end
                `WEI_ADDR_IRQ_STAT: begin
                    reg_rdata <= {29'h0, irq_stat_q};
                end
                `WEI_ADDR_IRQ_EN: begin
                    reg_rdata <= {29'h0, irq_en_q};
                end
                default: begin
                    reg_rdata <= 32'h0;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule
`default_nettype wire

// *** verif/wei_checker_asserts.sv ***
// Port checker for the wake event indicator
`timescale 1ns/1ps
`default_nettype none
`include "wei_consts.vh"
module wei_checker #(parameter int PULSE_CYCLES = 20) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic energy_event,
    input wire logic frame_event,
    input wire logic energy_src_pending,
    input wire logic frame_src_pending,
    input wire logic [1:0] power_state,
    input wire logic device_stable,
    input wire logic power_event_pin_o,
    input wire logic power_event_pin_oe,
    input wire logic power_event_irq
);
    logic [9:0] ctl_q;
    logic rdy_q;
    logic [7:0] hi_q;
    wire w84 = reg_wr && reg_addr == `WEI_ADDR_PWR_CTRL;
    wire r84 = reg_rd && reg_addr == `WEI_ADDR_PWR_CTRL;
    wire blk = !rdy_q || power_state != 2'h0 || energy_src_pending || frame_src_pending;
    wire act = power_event_irq && ctl_q[1];
    // Shadow of the control bits, so pin checks know the mode
    always @(posedge clk) begin
        if (!rst_b) begin
            {ctl_q, rdy_q, hi_q} <= '0;
        end else begin
            ctl_q <= w84 ? reg_wdata[9:0] : ctl_q;
            rdy_q <= device_stable;
            hi_q <= power_event_irq ? hi_q + {7'h00, hi_q != 8'hFF} : 8'h00;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Cause clear in held mode while the pin is active and no event arrives
    sequence s_clr;
        w84 && reg_wdata[9:8] == 2'h3 && reg_wdata[5:3] == 3'h6 && !ctl_q[3]
            && power_event_irq && !energy_event && !frame_event;
    endsequence
    a_clr_refused: assert property (s_clr ##0 blk |=> power_event_irq)
        else $error("blocked clear released pin");
    a_clr_done: assert property (s_clr ##0 !blk |-> ##[1:2] !power_event_irq)
        else $error("clear kept pin");
    a_en_release: assert property (w84 && reg_wdata[9:8] == 2'h0 |-> ##[1:2] !power_event_irq)
        else $error("enable clear kept pin");
    a_event_irq: assert property (energy_event && ctl_q[8] && !ctl_q[3] && !w84 |=> power_event_irq)
        else $error("event gave no irq");
    a_push_pull: assert property (ctl_q[6] |-> power_event_pin_oe && power_event_pin_o == (act ^ !ctl_q[2]))
        else $error("push-pull level wrong");
    a_open_drain: assert property (!ctl_q[6] |-> !power_event_pin_o && power_event_pin_oe == act)
        else $error("open-drain drive wrong");
    a_pulse_len: assert property (ctl_q[3] |-> hi_q <= PULSE_CYCLES)
        else $error("pulse too long");
    a_ready_rd: assert property (r84 |=> reg_rdata[0] == $past(device_stable, 2))
        else $error("ready bit wrong");
endmodule
bind wei_wake_event_indicator wei_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.*);
`default_nettype wire

// *** verif/wei_power_model.sv ***
// System power logic model: sleep request and settling delay
`timescale 1ns/1ps
`default_nettype none
module wei_power_model #(parameter logic [7:0] SETTLE = 8'h0C) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sleep_req,
    output logic device_stable,
    output logic [1:0] power_state
);
    logic [7:0] cnt_q;
    // Sleep drops stability at once; waking needs a settling count
    always @(posedge clk) begin
        if (!rst_b || sleep_req) cnt_q <= 8'h00;
        else if (cnt_q != SETTLE) cnt_q <= cnt_q + 8'h01;
    end
    assign device_stable = cnt_q == SETTLE;
    assign power_state = sleep_req ? 2'h2 : 2'h0;
endmodule
`default_nettype wire

// *** verif/wei_wake_event_indicator_test.sv ***
// Self-checking bench for the wake event indicator
`timescale 1ns/1ps
`default_nettype none
`include "wei_consts.vh"
module wei_wake_event_indicator_test;
    typedef struct packed {logic [9:0] ctl; logic [1:0] ev, cause; logic pin, pirq;} wei_row_t;
    localparam logic [7:0] CTL = `WEI_ADDR_PWR_CTRL;
    localparam logic [23:0] PULSE = 24'h14; // Short pulse keeps the run brief
    logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, sleep_req = 0;
    logic energy_event = 0, frame_event = 0, energy_src_pending = 0, frame_src_pending = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic device_stable, power_event_pin_o, power_event_pin_oe, power_event_irq, irq;
    logic [1:0] power_state;
    wire pin_w = power_event_pin_oe ? power_event_pin_o : 1'h1; // Board pull-up
    int num_errors = 0, tests_run = 0, i;
    wei_row_t rows [5] = '{'{10'h302, 2'h1, 2'h1, 1'h0, 1'h1}, '{10'h346, 2'h2, 2'h2, 1'h1, 1'h1},
        '{10'h342, 2'h3, 2'h3, 1'h0, 1'h1}, '{10'h306, 2'h2, 2'h2, 1'h0, 1'h1},
        '{10'h244, 2'h2, 2'h2, 1'h0, 1'h1}};
    always #2 clk = ~clk;
    wei_wake_event_indicator #(.PULSE_CYCLES(PULSE)) u_dut (.*);
    wei_power_model u_pwr (.*);
    task automatic chk(input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, v};
        @(posedge clk) reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk) {reg_rd, reg_addr} <= {1'h1, a};
        @(posedge clk) reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    // Energy first, then frame, so two causes arrive one after another
    task automatic ev(input logic [1:0] k);
        @(posedge clk) energy_event <= k[0];
        @(posedge clk) {energy_event, frame_event} <= {1'h0, k[1]};
        @(posedge clk) frame_event <= 0;
        repeat (2) @(posedge clk);
    endtask
    // Only the control register is polled until ready is seen
    task automatic wait_ready;
        for (i = 0; i < 50; i++) begin
            rd(CTL);
            if (d[0] === 1'h1) return;
        end
        num_errors++;
        summarize;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1;
        @(posedge clk) #1 chk({power_event_pin_oe, power_event_irq, irq}, 3'h0);
        wait_ready;
        chk(d[6:1], 6'h00);
        foreach (rows[r]) begin
            wr(CTL, {22'h0, rows[r].ctl});
            ev(rows[r].ev);
            rd(CTL);
            chk({d[5:4], pin_w, power_event_irq}, rows[r][3:0]);
            wr(CTL, {22'h0, rows[r].ctl} | 32'h30);
            rd(CTL);
            chk({d[5:4], power_event_irq}, 3'h0);
        end
        // Pending source, then low power: the cause must survive both
        wr(CTL, 32'h346);
        ev(2'h1);
        energy_src_pending <= 1;
        wr(CTL, 32'h376);
        rd(CTL);
        chk(d[5:4], 2'h1);
        energy_src_pending <= 0;
        sleep_req <= 1;
        wr(CTL, 32'h376);
        rd(CTL);
        chk({d[13:12], d[5:4], pin_w, d[0]}, 6'h26);
        sleep_req <= 0;
        wait_ready;
        wr(CTL, 32'h376);
        rd(CTL);
        chk(d[5:4], 2'h0);
        wr(CTL, 32'h34E);
        @(posedge clk) energy_event <= 1;
        @(posedge clk) energy_event <= 0;
        #1;
        for (i = 0; i < 99 && pin_w === 1'h1; i++) @(posedge clk) #1;
        chk(i, PULSE);
        wr(CTL, 32'h376);
        wr(CTL, 32'h346);
        ev(2'h1);
        repeat (30) @(posedge clk);
        #1 chk(pin_w, 1'h1);
        wr(CTL, 32'h046);
        @(posedge clk) #1 chk(pin_w, 1'h0);
        // Interrupt: raise, mask, unmask, clear
        wr(CTL, 32'h376);
        wr(`WEI_ADDR_IRQ_CLR, 32'h7);
        wr(`WEI_ADDR_IRQ_EN, 32'h1);
        ev(2'h3);
        rd(`WEI_ADDR_IRQ_STAT);
        chk({d[2:0], irq}, 4'h7);
        wr(`WEI_ADDR_IRQ_EN, 32'h4);
        @(posedge clk) #1 chk(irq, 1'h0);
        wr(`WEI_ADDR_IRQ_EN, 32'h1);
        @(posedge clk) #1 chk(irq, 1'h1);
        wr(`WEI_ADDR_IRQ_CLR, 32'h1);
        @(posedge clk) #1 chk(irq, 1'h0);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40);
        chk(d, 32'h0);
        wr(CTL, 32'h330);
        rd(CTL);
        chk(d[13:0], 14'h0301);
        summarize;
    end
endmodule
`default_nettype wire
